// [core/pin_sync.v]
// Purpose: two flip-flop synchroniser for asynchronous pin inputs
// Assumes: inputs change independently of clk_in
// Notes: the first stage is read only by the second stage
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
  parameter W = 1,
  parameter [W-1:0] RESET_VAL = {W{1'b0}}
) (
  // clock and reset
  input wire clk_in,
  input wire resetn_in,
  // data
  input wire [W-1:0] d_in,
  output wire [W-1:0] q_out
);

  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      meta_r <= RESET_VAL;
      sync_r <= RESET_VAL;
    end
    else
    begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign q_out = sync_r;

endmodule // pin_sync

`default_nettype wire

// [core/vme_decode_map.vh]
// Purpose: shared constants for the short I/O slave decoder
// Assumes: included by bare name from the design files
// Notes: definitions only
`ifndef VME_DECODE_MAP_VH
`define VME_DECODE_MAP_VH

// ----------------------------------------
// address modifier codes
// ----------------------------------------
`define AM_SHORT_SUP 6'h2D
`define AM_SHORT_NPRIV 6'h29
`define AM_STD_SUP 6'h3D
`define AM_STD_NPRIV 6'h39

// ----------------------------------------
// standard space segment
// ----------------------------------------
`define STD_TOP_SEGMENT 8'hFF

// ----------------------------------------
// strap field positions inside the synchronised strap word: base and space bank, space strap, level
// ----------------------------------------
`define BANK_BASE_HI 5
`define BANK_BASE_LO 0
`define BANK_PRIV_BIT 6
`define BANK_SPACE_BIT 7
`define STRAP_STD_BIT 8
`define STRAP_LEVEL_HI 11
`define STRAP_LEVEL_LO 9

// ----------------------------------------
// address fields on the expansion bus
// ----------------------------------------
`define ADDR_BASE_HI 15
`define ADDR_BASE_LO 10
`define ADDR_SEG_HI 23
`define ADDR_SEG_LO 16
`define ADDR_LEVEL_HI 3
`define ADDR_LEVEL_LO 1

// ----------------------------------------
// register byte offsets on the control bus
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_VECTOR 8'h04
`define REG_STATUS 8'h08
`define REG_HITCOUNT 8'h0C

// ----------------------------------------
// register fields and reset values
// ----------------------------------------
`define CTRL_ENABLE_BIT 0
`define CTRL_IRQ_REQ_BIT 1
`define CTRL_RESET 1'h1
`define VECTOR_RESET 8'h00

// ----------------------------------------
// bus responses
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [core/vme_slave_address_decode.v]
// Purpose: strap-configured slave decoder for a 16-bit I/O module on the expansion bus
// Assumes: all bus pins and straps are asynchronous and pass two flip-flops
// Notes: open-drain pins are out/oe pairs; oe high while this block pulls low
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`include "vme_decode_map.vh"
`timescale 1ns/1ns
`default_nettype none

module vme_slave_address_decode #(
  parameter RAM_AW = 9
) (
  // clock and reset
  input wire clk_in,
  input wire resetn_in,
  // control bus write address and data
  input wire [7:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output reg s_axi_awready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output reg s_axi_wready_out,
  output reg [1:0] s_axi_bresp_out,
  output reg s_axi_bvalid_out,
  input wire s_axi_bready_in,
  // control bus read
  input wire [7:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output reg s_axi_arready_out,
  output reg [31:0] s_axi_rdata_out,
  output reg [1:0] s_axi_rresp_out,
  output reg s_axi_rvalid_out,
  input wire s_axi_rready_in,
  // straps
  input wire [7:0] base_and_space_switch_bank_in,
  input wire space_select_strap_in,
  input wire [2:0] irq_level_switch_bank_in,
  // expansion bus pins
  input wire [23:1] vme_addr_in,
  input wire [5:0] vme_am_in,
  input wire vme_as_n_in,
  input wire [1:0] vme_ds_n_in,
  input wire vme_write_n_in,
  input wire vme_iack_n_in,
  input wire vme_iackin_n_in,
  input wire [15:0] vme_data_in,
  output reg [15:0] vme_data_out,
  output reg vme_data_oe_out,
  output reg vme_dtack_n_out,
  output reg vme_dtack_oe_out,
  output reg [6:0] vme_irq_n_out,
  output reg [6:0] vme_irq_oe_out,
  output reg vme_iackout_n_out
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_READ = 3'h1;
  localparam [2:0] S_ACK = 3'h2;
  localparam [2:0] S_PASS = 3'h3;
  localparam [2:0] S_MISS = 3'h4;

  // ----------------------------------------
  // synchronised pins and straps
  // ----------------------------------------
  wire [23:1] addr_s;
  wire [5:0] am_s;
  wire [15:0] data_s;
  wire [5:0] ctl_s;
  wire [11:0] strap_s;
  wire as_s = ctl_s[0];
  wire [1:0] ds_s = ctl_s[2:1];
  wire write_s = ctl_s[3];
  wire iack_s = ctl_s[4];
  wire iackin_s = ctl_s[5];

  pin_sync #(.W(23)) u_sync_addr (
    .clk_in(clk_in), .resetn_in(resetn_in), .d_in(vme_addr_in), .q_out(addr_s));
  pin_sync #(.W(6)) u_sync_am (
    .clk_in(clk_in), .resetn_in(resetn_in), .d_in(vme_am_in), .q_out(am_s));
  pin_sync #(.W(16)) u_sync_data (
    .clk_in(clk_in), .resetn_in(resetn_in), .d_in(vme_data_in), .q_out(data_s));
  // strobes idle high, so they reset high to avoid a false cycle
  pin_sync #(.W(6), .RESET_VAL(6'h3F)) u_sync_ctl (
    .clk_in(clk_in), .resetn_in(resetn_in),
    .d_in({vme_iackin_n_in, vme_iack_n_in, vme_write_n_in, vme_ds_n_in, vme_as_n_in}),
    .q_out(ctl_s));
  pin_sync #(.W(12)) u_sync_strap (
    .clk_in(clk_in), .resetn_in(resetn_in),
    .d_in({irq_level_switch_bank_in, space_select_strap_in, base_and_space_switch_bank_in}),
    .q_out(strap_s));

  wire [5:0] base_sw = strap_s[`BANK_BASE_HI:`BANK_BASE_LO];
  wire priv_open = strap_s[`BANK_PRIV_BIT];
  wire space_open = strap_s[`BANK_SPACE_BIT];
  wire strap_std = strap_s[`STRAP_STD_BIT];
  wire [2:0] irq_level = strap_s[`STRAP_LEVEL_HI:`STRAP_LEVEL_LO];

  // ----------------------------------------
  // decode
  // ----------------------------------------
  // a mismatched strap and switch pair selects no space at all
  wire mode_std = strap_std & space_open;
  wire mode_short = ~strap_std & ~space_open;

  function am_accept;
    input [5:0] am;
    input is_std;
    input sup_only;
    begin
      if (is_std)
        am_accept = (am == `AM_STD_SUP) || (!sup_only && am == `AM_STD_NPRIV);
      else
        am_accept = (am == `AM_SHORT_SUP) || (!sup_only && am == `AM_SHORT_NPRIV);
    end
  endfunction

  // open switch reads as one, so the bank compares directly with A15..A10
  wire base_match = (addr_s[`ADDR_BASE_HI:`ADDR_BASE_LO] == base_sw);
  wire top_match = (addr_s[`ADDR_SEG_HI:`ADDR_SEG_LO] == `STD_TOP_SEGMENT);
  wire am_ok = am_accept(am_s, mode_std, priv_open);
  wire hit = base_match & am_ok & ((mode_std & top_match) | mode_short);
  wire cycle_start = ~as_s & (ds_s != 2'h3);

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  reg enable_r;
  reg irq_pend_r;
  reg [7:0] vector_r;
  reg [15:0] hit_count_r;
  reg [2:0] state_r;
  reg aw_got_r;
  reg w_got_r;
  reg [7:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;

  // ----------------------------------------
  // bus cycle engine
  // ----------------------------------------
  wire [2:0] irq_idx = irq_level - 3'h1;
  wire iack_ours = irq_pend_r & (irq_level != 3'h0) &
                   (addr_s[`ADDR_LEVEL_HI:`ADDR_LEVEL_LO] == irq_level);
  wire ram_wr = (state_r == S_IDLE) & enable_r & cycle_start & iack_s & hit & ~write_s;
  wire [15:0] ram_rdata;
  reg iack_done;

  window_ram #(.AW(RAM_AW), .DW(16)) u_ram (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .addr_in(addr_s[RAM_AW:1]),
    .wr_en_in(ram_wr),
    .byte_en_in(~ds_s),
    .wdata_in(data_s),
    .rdata_out(ram_rdata)
  );

  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_r <= S_IDLE;
      vme_data_out <= 16'h0000;
      vme_data_oe_out <= 1'b0;
      vme_dtack_n_out <= 1'b1;
      vme_dtack_oe_out <= 1'b0;
      vme_iackout_n_out <= 1'b1;
      hit_count_r <= 16'h0000;
    end
    else
    begin
      case (state_r)
        S_IDLE:
        begin
          if (cycle_start && !iack_s && !iackin_s)
          begin
            if (iack_ours && enable_r)
            begin
              vme_data_out <= {8'h00, vector_r};
              vme_data_oe_out <= 1'b1;
              vme_dtack_n_out <= 1'b0;
              vme_dtack_oe_out <= 1'b1;
              state_r <= S_ACK;
            end
            else
            begin
              vme_iackout_n_out <= 1'b0;
              state_r <= S_PASS;
            end
          end
          else if (cycle_start && iack_s && enable_r && hit)
          begin
            hit_count_r <= hit_count_r + 16'h0001;
            if (write_s)
              state_r <= S_READ;
            else
            begin
              vme_dtack_n_out <= 1'b0;
              vme_dtack_oe_out <= 1'b1;
              state_r <= S_ACK;
            end
          end
          else if (cycle_start && iack_s)
            state_r <= S_MISS;
        end
        S_READ:
        begin
          vme_data_out <= ram_rdata;
          vme_data_oe_out <= 1'b1;
          vme_dtack_n_out <= 1'b0;
          vme_dtack_oe_out <= 1'b1;
          state_r <= S_ACK;
        end
        S_ACK:
        begin
          if (ds_s == 2'h3)
          begin
            vme_data_oe_out <= 1'b0;
            vme_dtack_n_out <= 1'b1;
            vme_dtack_oe_out <= 1'b0;
            if (as_s)
              state_r <= S_IDLE;
            else
              state_r <= S_MISS;
          end
        end
        S_PASS:
        begin
          if (as_s || iackin_s)
          begin
            vme_iackout_n_out <= 1'b1;
            state_r <= S_MISS;
          end
        end
        S_MISS:
        begin
          // a failed decode stays silent until the strobe ends
          if (as_s)
            state_r <= S_IDLE;
        end
        default:
          state_r <= S_IDLE;
      endcase
    end
  end

  always @*
  begin
    iack_done = (state_r == S_IDLE) & cycle_start & ~iack_s & ~iackin_s & iack_ours & enable_r;
  end

  // ----------------------------------------
  // interrupt request pins
  // ----------------------------------------
  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      vme_irq_n_out <= 7'h7F;
      vme_irq_oe_out <= 7'h00;
    end
    else
    begin
      vme_irq_n_out <= 7'h7F;
      vme_irq_oe_out <= 7'h00;
      if (irq_pend_r && enable_r && irq_level != 3'h0)
      begin
        vme_irq_n_out[irq_idx] <= 1'b0;
        vme_irq_oe_out[irq_idx] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // control bus slave
  // ----------------------------------------
  wire wr_fire = aw_got_r & w_got_r & ~s_axi_bvalid_out;
  wire irq_set = wr_fire & (awaddr_r == `REG_CTRL) & wstrb_r[0] & wdata_r[`CTRL_IRQ_REQ_BIT];
  wire wr_known = (awaddr_r == `REG_CTRL) || (awaddr_r == `REG_VECTOR);
  wire rd_known = (s_axi_araddr_in == `REG_CTRL) || (s_axi_araddr_in == `REG_VECTOR) ||
                  (s_axi_araddr_in == `REG_STATUS) || (s_axi_araddr_in == `REG_HITCOUNT);
  reg [31:0] rd_word;

  always @*
  begin
    rd_word = 32'h00000000;
    case (s_axi_araddr_in)
      `REG_CTRL: rd_word = {30'h0, irq_pend_r, enable_r};
      `REG_VECTOR: rd_word = {24'h000000, vector_r};
      `REG_STATUS: rd_word = {17'h0, state_r, irq_level, strap_s[8:0]};
      `REG_HITCOUNT: rd_word = {16'h0000, hit_count_r};
      default: rd_word = 32'h00000000;
    endcase
  end

  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out <= 1'b1;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `RESP_OKAY;
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rresp_out <= `RESP_OKAY;
      s_axi_rdata_out <= 32'h00000000;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      enable_r <= `CTRL_RESET;
      vector_r <= `VECTOR_RESET;
      irq_pend_r <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
        awaddr_r <= s_axi_awaddr_in;
        aw_got_r <= 1'b1;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
        wdata_r <= s_axi_wdata_in;
        wstrb_r <= s_axi_wstrb_in;
        w_got_r <= 1'b1;
        s_axi_wready_out <= 1'b0;
      end
      if (wr_fire)
      begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
        if (awaddr_r == `REG_CTRL && wstrb_r[0])
          enable_r <= wdata_r[`CTRL_ENABLE_BIT];
        if (awaddr_r == `REG_VECTOR && wstrb_r[0])
          vector_r <= wdata_r[7:0];
      end
      if (s_axi_bvalid_out && s_axi_bready_in)
      begin
        s_axi_bvalid_out <= 1'b0;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out <= 1'b1;
      end
      // a software request in the acknowledge cycle wins over the clear
      if (irq_set)
        irq_pend_r <= 1'b1;
      else if (iack_done)
        irq_pend_r <= 1'b0;
      if (s_axi_arvalid_in && s_axi_arready_out)
      begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out <= rd_word;
        s_axi_rresp_out <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_rvalid_out && s_axi_rready_in)
      begin
        s_axi_rvalid_out <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end
  end

endmodule // vme_slave_address_decode

`default_nettype wire

// [core/window_ram.v]
// Purpose: backing store for the one kilobyte interface window
// Assumes: 16-bit words with two byte lanes
// Notes: read data come out of a register one cycle after the address
`timescale 1ns/1ns
`default_nettype none

module window_ram #(
  parameter AW = 9,
  parameter DW = 16
) (
  // clock and reset
  input wire clk_in,
  input wire resetn_in,
  // access
  input wire [AW-1:0] addr_in,
  input wire wr_en_in,
  input wire [1:0] byte_en_in,
  input wire [DW-1:0] wdata_in,
  output reg [DW-1:0] rdata_out
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk_in)
  begin
    if (wr_en_in && byte_en_in[0])
      mem[addr_in][DW/2-1:0] <= wdata_in[DW/2-1:0];
    if (wr_en_in && byte_en_in[1])
      mem[addr_in][DW-1:DW/2] <= wdata_in[DW-1:DW/2];
  end

  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rdata_out <= {DW{1'b0}};
    else
      rdata_out <= mem[addr_in];
  end

endmodule // window_ram

`default_nettype wire

// [sim/vme_master_model.sv]
// Purpose: bus master standing in for the host processor
// Assumes: one word or acknowledge cycle at a time, both data strobes
// Notes: released lines show the inverse of their last value
`timescale 1ns/1ns
`default_nettype none
module vme_master_model (
  // clock
  input wire logic clk_in,
  // towards the slave
  output logic [23:1] addr_out = 23'h0,
  output logic [5:0] am_out = 6'h0,
  output logic as_n_out = 1'h1,
  output logic [1:0] ds_n_out = 2'h3,
  output logic write_n_out = 1'h1,
  output logic iack_n_out = 1'h1,
  output logic iackin_n_out = 1'h1,
  output logic [15:0] data_out = 16'h0,
  // from the slave
  input wire logic [15:0] data_in,
  input wire logic data_oe_in,
  input wire logic dtack_n_in,
  input wire logic dtack_oe_in,
  input wire logic iackout_n_in
);
  // got: bit0 acknowledged, bit1 passed down the chain; 16 clocks is the bus timeout
  task automatic cycle(input logic ia, input logic wr, input logic [23:1] a,
    input logic [5:0] m, input logic [15:0] wd, output logic [1:0] got,
    output logic [15:0] rd);
    int n;
    got = 2'h0;
    addr_out <= a;
    am_out <= m;
    write_n_out <= ~wr;
    iack_n_out <= ~ia;
    iackin_n_out <= ~ia;
    data_out <= wr ? wd : ~data_out;
    as_n_out <= 1'h0;
    ds_n_out <= 2'h0;
    for (n = 0; n < 16 && got == 2'h0; n++)
    begin
      @(posedge clk_in);
      got = {~iackout_n_in, ~dtack_n_in & dtack_oe_in};
    end
    rd = data_oe_in ? data_in : 16'hDEAD;
    as_n_out <= 1'h1;
    ds_n_out <= 2'h3;
    iack_n_out <= 1'h1;
    iackin_n_out <= 1'h1;
    addr_out <= ~addr_out;
    am_out <= ~am_out;
    data_out <= ~data_out;
    repeat (6) @(posedge clk_in);
  endtask
endmodule // vme_master_model
`default_nettype wire

// [sim/vme_slave_address_decode_assertions.sv]
// Purpose: port checks for the strap decoder
// Assumes: straps and level change only while the bus is idle
// Notes: pins pass two sync flops, so decode causes are looked up two clocks back; strobe and chain causes one clock back
`timescale 1ns/1ns
`default_nettype none
module vsd_checker (
  // clock and reset
  input wire clk_in,
  input wire resetn_in,
  // straps
  input wire [7:0] base_and_space_switch_bank_in,
  input wire space_select_strap_in,
  input wire [2:0] irq_level_switch_bank_in,
  // bus pins
  input wire [23:1] vme_addr_in,
  input wire [5:0] vme_am_in,
  input wire [1:0] vme_ds_n_in,
  input wire vme_iack_n_in,
  input wire vme_iackin_n_in,
  input wire vme_data_oe_out,
  input wire vme_dtack_n_out,
  input wire vme_dtack_oe_out,
  input wire [6:0] vme_irq_oe_out,
  input wire vme_iackout_n_out
);
  wire [7:0] bk = base_and_space_switch_bank_in;
  wire in_std = space_select_strap_in;
  wire [5:0] am = vme_am_in;
  wire am_ok = in_std ? (am == 6'h3D || (am == 6'h39 && !bk[6]))
    : (am == 6'h2D || (am == 6'h29 && !bk[6]));
  wire hit = in_std == bk[7] && (!in_std || vme_addr_in[23:16] == 8'hFF)
    && vme_addr_in[15:10] == bk[5:0] && am_ok;
  wire lvl_hit = vme_addr_in[3:1] == irq_level_switch_bank_in;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  ack_decode_a: assert property
    ($fell(vme_dtack_n_out) && $past(vme_iack_n_in, 2) |-> $past(hit, 2))
    else $error("acknowledge without a decode hit");
  data_decode_a: assert property
    ($rose(vme_data_oe_out) && $past(vme_iack_n_in, 2) |-> $past(hit, 2))
    else $error("data driven without a decode hit");
  data_ack_a: assert property
    (vme_data_oe_out |-> vme_dtack_oe_out && !vme_dtack_n_out)
    else $error("data driven without acknowledge");
  ack_release_a: assert property
    ($fell(vme_dtack_oe_out) |-> $past(vme_ds_n_in) == 2'h3)
    else $error("acknowledge dropped while strobes low");
  irq_level_a: assert property
    (vme_irq_oe_out != 7'h00 |-> vme_irq_oe_out == 7'h01 << (irq_level_switch_bank_in - 3'h1))
    else $error("request on the wrong level");
  vector_level_a: assert property
    ($fell(vme_dtack_n_out) && !$past(vme_iack_n_in, 2) |-> $past(lvl_hit, 2))
    else $error("vector given for another level");
  pass_cause_a: assert property
    ($fell(vme_iackout_n_out) |-> !$past(vme_iackin_n_in) && !$past(vme_iack_n_in))
    else $error("daisy chain passed without acknowledge in");
  pass_excl_a: assert property
    (!vme_iackout_n_out |-> !vme_dtack_oe_out && !vme_data_oe_out)
    else $error("answered and passed on at once");
endmodule // vsd_checker

bind vme_slave_address_decode vsd_checker i_vsd_checker (
  .clk_in, .resetn_in, .base_and_space_switch_bank_in, .space_select_strap_in,
  .irq_level_switch_bank_in, .vme_addr_in, .vme_am_in, .vme_ds_n_in, .vme_iack_n_in,
  .vme_iackin_n_in, .vme_data_oe_out, .vme_dtack_n_out, .vme_dtack_oe_out,
  .vme_irq_oe_out, .vme_iackout_n_out
);
`default_nettype wire

// [sim/vme_slave_address_decode_tb_top.sv]
// Purpose: directed bench for the strap decoder
// Assumes: the master model works the bus, control bus driven here
// Notes: a missed cycle ends on the model's own bus timeout
`timescale 1ns/1ns
`default_nettype none
module vme_slave_address_decode_tb_top;
  logic clk_in = 1'h0, resetn_in = 1'h0;
  logic [7:0] s_axi_awaddr_in = 8'h0, s_axi_araddr_in = 8'h0;
  logic [31:0] s_axi_wdata_in = 32'h0;
  logic [3:0] s_axi_wstrb_in = 4'hF;
  logic s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0, s_axi_bready_in = 1'h0;
  logic s_axi_arvalid_in = 1'h0, s_axi_rready_in = 1'h0;
  logic [7:0] base_and_space_switch_bank_in = 8'h0;
  logic space_select_strap_in = 1'h0;
  logic [2:0] irq_level_switch_bank_in = 3'h0;
  wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  wire s_axi_rvalid_out, vme_as_n_in, vme_write_n_in, vme_iack_n_in, vme_iackin_n_in;
  wire vme_data_oe_out, vme_dtack_n_out, vme_dtack_oe_out, vme_iackout_n_out;
  wire [1:0] s_axi_bresp_out, s_axi_rresp_out, vme_ds_n_in;
  wire [31:0] s_axi_rdata_out;
  wire [23:1] vme_addr_in;
  wire [5:0] vme_am_in;
  wire [15:0] vme_data_in, vme_data_out;
  wire [6:0] vme_irq_n_out, vme_irq_oe_out;
  int err_count = 0, checks = 0, cyc = 0;

  always #10 clk_in = ~clk_in;

  vme_slave_address_decode #(.RAM_AW(9)) i_vme_slave_address_decode (
    .clk_in, .resetn_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
    .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
    .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in,
    .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
    .s_axi_rvalid_out, .s_axi_rready_in, .base_and_space_switch_bank_in,
    .space_select_strap_in, .irq_level_switch_bank_in, .vme_addr_in, .vme_am_in,
    .vme_as_n_in, .vme_ds_n_in, .vme_write_n_in, .vme_iack_n_in, .vme_iackin_n_in,
    .vme_data_in, .vme_data_out, .vme_data_oe_out, .vme_dtack_n_out, .vme_dtack_oe_out,
    .vme_irq_n_out, .vme_irq_oe_out, .vme_iackout_n_out);

  vme_master_model i_vme_master_model (
    .clk_in(clk_in), .addr_out(vme_addr_in), .am_out(vme_am_in), .as_n_out(vme_as_n_in),
    .ds_n_out(vme_ds_n_in), .write_n_out(vme_write_n_in), .iack_n_out(vme_iack_n_in),
    .iackin_n_out(vme_iackin_n_in), .data_out(vme_data_in), .data_in(vme_data_out),
    .data_oe_in(vme_data_oe_out), .dtack_n_in(vme_dtack_n_out),
    .dtack_oe_in(vme_dtack_oe_out), .iackout_n_in(vme_iackout_n_out));

  task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", w, e, s);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // waits for the answer as long as it takes; the cycle ceiling catches a hang
  // one edge first, so a new request never meets the last one's release
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'h1;
    s_axi_wvalid_in <= 1'h1;
    s_axi_bready_in <= 1'h1;
    while (!s_axi_bvalid_out)
    begin
      @(posedge clk_in);
      if (s_axi_awready_out)
        s_axi_awvalid_in <= 1'h0;
      if (s_axi_wready_out)
        s_axi_wvalid_in <= 1'h0;
    end
    s_axi_bready_in <= 1'h0;
    chk("write answer", {29'h0, s_axi_bvalid_out, s_axi_bresp_out}, {29'h1, er});
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'h1;
    s_axi_rready_in <= 1'h1;
    while (!s_axi_rvalid_out)
    begin
      @(posedge clk_in);
      if (s_axi_arready_out)
        s_axi_arvalid_in <= 1'h0;
    end
    s_axi_rready_in <= 1'h0;
    chk("read answer", {29'h0, s_axi_rvalid_out, s_axi_rresp_out}, {29'h1, er});
    chk("read data", s_axi_rdata_out, ed);
  endtask

  task automatic cfg(input logic [7:0] b, input logic s, input logic [2:0] l);
    base_and_space_switch_bank_in <= b;
    space_select_strap_in <= s;
    irq_level_switch_bank_in <= l;
    repeat (4) @(posedge clk_in);
  endtask

  task automatic vb(input logic ia, input logic wr, input logic [23:0] a, input logic [5:0] m,
    input logic [15:0] wd, input logic [1:0] eg, input logic [15:0] er);
    logic [1:0] g;
    logic [15:0] r;
    i_vme_master_model.cycle(ia, wr, a[23:1], m, wd, g, r);
    if (ia)
      r[15:8] = er[15:8];
    chk("bus answer", {30'h0, g}, {30'h0, eg});
    if (eg[0] && !wr)
      chk("bus data", {16'h0, r}, {16'h0, er});
  endtask

  task automatic t_regs;
    axr(8'h00, 32'h1, 2'h0);
    axr(8'h04, 32'h0, 2'h0);
    axr(8'h10, 32'h0, 2'h2);
    axw(8'h10, 32'hFFFF, 2'h2);
    axw(8'h04, 32'h5A, 2'h0);
    axr(8'h04, 32'h5A, 2'h0);
    $display("test registers done");
  endtask

  task automatic t_short;
    cfg(8'h2D, 1'h0, 3'h0);
    vb(1'h0, 1'h1, 24'h00B7FE, 6'h2D, 16'h1234, 2'h1, 16'h0);
    vb(1'h0, 1'h0, 24'h00B7FE, 6'h29, 16'h0, 2'h1, 16'h1234);
    vb(1'h0, 1'h0, 24'h00B800, 6'h2D, 16'h0, 2'h0, 16'h0);
    vb(1'h0, 1'h0, 24'h00B3FE, 6'h2D, 16'h0, 2'h0, 16'h0);
    vb(1'h0, 1'h0, 24'h00B400, 6'h3D, 16'h0, 2'h0, 16'h0);
    cfg(8'h6D, 1'h0, 3'h0);
    vb(1'h0, 1'h0, 24'h00B7FE, 6'h29, 16'h0, 2'h0, 16'h0);
    vb(1'h0, 1'h0, 24'h00B7FE, 6'h2D, 16'h0, 2'h1, 16'h1234);
    cfg(8'h2D, 1'h1, 3'h0);
    vb(1'h0, 1'h0, 24'hFFB7FE, 6'h3D, 16'h0, 2'h0, 16'h0);
    $display("test short space done");
  endtask

  task automatic t_std;
    cfg(8'hAD, 1'h1, 3'h0);
    vb(1'h0, 1'h1, 24'hFFB400, 6'h3D, 16'h5A5A, 2'h1, 16'h0);
    vb(1'h0, 1'h0, 24'hFFB400, 6'h39, 16'h0, 2'h1, 16'h5A5A);
    vb(1'h0, 1'h0, 24'hFEB400, 6'h3D, 16'h0, 2'h0, 16'h0);
    vb(1'h0, 1'h0, 24'hFFB400, 6'h2D, 16'h0, 2'h0, 16'h0);
    cfg(8'hED, 1'h1, 3'h0);
    vb(1'h0, 1'h0, 24'hFFB400, 6'h39, 16'h0, 2'h0, 16'h0);
    cfg(8'hAD, 1'h0, 3'h0);
    vb(1'h0, 1'h0, 24'h00B400, 6'h2D, 16'h0, 2'h0, 16'h0);
    $display("test standard space done");
  endtask

  // every window maps onto the same store, so word zero reads back everywhere
  task automatic t_base;
    for (int i = 0; i < 6; i++)
    begin
      cfg({2'h0, 6'h01 << i}, 1'h0, 3'h0);
      vb(1'h0, 1'h0, 24'h000400 << i, 6'h2D, 16'h0, 2'h1, 16'h5A5A);
      vb(1'h0, 1'h0, 24'h000400 << (5 - i), 6'h2D, 16'h0, 2'h0, 16'h0);
    end
    $display("test base switches done");
  endtask

  task automatic t_enable;
    cfg(8'h2D, 1'h0, 3'h0);
    axw(8'h00, 32'h0, 2'h0);
    vb(1'h0, 1'h0, 24'h00B400, 6'h2D, 16'h0, 2'h0, 16'h0);
    axw(8'h00, 32'h1, 2'h0);
    vb(1'h0, 1'h0, 24'h00B400, 6'h2D, 16'h0, 2'h1, 16'h5A5A);
    // twelve claimed data cycles so far; misses and disabled cycles do not count
    axr(8'h0C, 32'hC, 2'h0);
    $display("test enable done");
  endtask

  task automatic t_irq;
    cfg(8'h2D, 1'h0, 3'h3);
    axw(8'h04, 32'hA5, 2'h0);
    axw(8'h00, 32'h3, 2'h0);
    repeat (4) @(posedge clk_in);
    chk("irq pins", {vme_irq_n_out, vme_irq_oe_out}, {7'h7B, 7'h04});
    axr(8'h00, 32'h3, 2'h0);
    vb(1'h1, 1'h0, 24'h00000A, 6'h2D, 16'h0, 2'h2, 16'h0);
    vb(1'h1, 1'h0, 24'h000006, 6'h2D, 16'h0, 2'h1, 16'h00A5);
    chk("irq pins", {vme_irq_n_out, vme_irq_oe_out}, {7'h7F, 7'h00});
    vb(1'h1, 1'h0, 24'h000006, 6'h2D, 16'h0, 2'h2, 16'h0);
    cfg(8'h2D, 1'h0, 3'h0);
    axw(8'h00, 32'h3, 2'h0);
    repeat (4) @(posedge clk_in);
    chk("irq pins", {vme_irq_n_out, vme_irq_oe_out}, {7'h7F, 7'h00});
    cfg(8'h2D, 1'h0, 3'h7);
    chk("irq pins", {vme_irq_n_out, vme_irq_oe_out}, {7'h3F, 7'h40});
    axr(8'h08, 32'hE2D, 2'h0);
    vb(1'h1, 1'h0, 24'h00000E, 6'h2D, 16'h0, 2'h1, 16'h00A5);
    $display("test interrupt done");
  endtask

  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      err_count++;
      conclude;
    end
  end

  initial
  begin
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'h1;
    repeat (3) @(posedge clk_in);
    t_regs;
    t_short;
    t_std;
    t_base;
    t_enable;
    t_irq;
    conclude;
  end
endmodule // vme_slave_address_decode_tb_top
`default_nettype wire
